// ===== rtl/sec_bus_arbiter.sv
// secondary bus arbiter for the bridge and six external masters, axi4-lite registers
// assumes bus pins arrive asynchronously and i_bridge_req/i_link_reset are on i_mclk
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module sec_bus_arbiter #(
    parameter int TO_CLKS = sec_arb_pkg::TIMEOUT_CYCLES
) (
    // clock and resets
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_link_reset,
    input wire logic i_global_reset_input_n,
    // axi4-lite slave
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // secondary bus
    input wire logic [sec_arb_pkg::REQ_N-1:0] i_request_in_n,
    output logic [sec_arb_pkg::REQ_N-1:0] o_grant_out_n,
    input wire logic i_frame_n,
    input wire logic i_irdy_n,
    // bridge's own master
    input wire logic i_bridge_req,
    output logic o_bridge_gnt
);
    import sec_arb_pkg::*;

    if (TO_CLKS < 2 || TO_CLKS > 255)
    begin : g_bad_to
        $error("TO_CLKS must lie in 2..255");
    end

    localparam logic [7:0] CNT_LAST = 8'(TO_CLKS - 1);

    logic [5:0] req_s1_ff, req_s2_ff;
    logic frame_s1_ff, frame_s2_ff, irdy_s1_ff, irdy_s2_ff, glob_s1_ff, glob_s2_ff;
    logic rst;

    // two-stage synchronisers; only stage two is read
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            req_s1_ff <= 6'h3f;
            req_s2_ff <= 6'h3f;
            frame_s1_ff <= 1'b1;
            frame_s2_ff <= 1'b1;
            irdy_s1_ff <= 1'b1;
            irdy_s2_ff <= 1'b1;
            glob_s1_ff <= 1'b1;
            glob_s2_ff <= 1'b1;
        end
        else
        begin
            req_s1_ff <= i_request_in_n;
            req_s2_ff <= req_s1_ff;
            frame_s1_ff <= i_frame_n;
            frame_s2_ff <= frame_s1_ff;
            irdy_s1_ff <= i_irdy_n;
            irdy_s2_ff <= irdy_s1_ff;
            glob_s1_ff <= i_global_reset_input_n;
            glob_s2_ff <= glob_s1_ff;
        end
    end

    assign rst = !i_rstn || i_link_reset || !glob_s2_ff;

    function automatic logic [3:0] rr_pick(input logic [6:0] req, input logic [2:0] last);
        logic [3:0] res;
        int j;
        res = 4'h0;
        for (int k = 7; k >= 1; k--)
        begin
            j = (int'(last) + k) % 7;
            if (req[j])
                res = {1'b1, 3'(j)};
        end
        return res;
    endfunction : rr_pick

    arb_ctrl_s ctrl_ff, nxt_ctrl;
    req_mask_s mask_ff, nxt_mask;
    logic [5:0] to_flag_ff, nxt_to_flag, automask_ff, nxt_automask;
    arb_state_e state_ff, nxt_state;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [2:0] own_ff, nxt_own, last_hi_ff, nxt_last_hi, last_lo_ff, nxt_last_lo;
    logic [5:0] gnt_n_ff, nxt_gnt_n;
    logic bridge_gnt_ff, nxt_bridge_gnt;
    logic [6:0] req_raw, tier7, hi_req, lo_req, cur;
    logic [3:0] pick_hi, pick_lo;
    logic bus_idle, expire;

    logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
    logic [9:0] awidx_ff, nxt_awidx;
    logic [7:0] wbyte_ff, nxt_wbyte;
    logic wstrb0_ff, nxt_wstrb0;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic do_wr, ar_take;
    logic [9:0] aridx;
    logic [5:0] w1c;

    assign bus_idle = frame_s2_ff && irdy_s2_ff;
    assign req_raw = {i_bridge_req, ~req_s2_ff & ~mask_ff.ignore & ~automask_ff};
    assign tier7 = {ctrl_ff.bridge_tier, ctrl_ff.tier};
    assign hi_req = req_raw & tier7;
    assign lo_req = req_raw & ~tier7;
    assign pick_hi = rr_pick(hi_req, last_hi_ff);
    assign pick_lo = rr_pick(lo_req, last_lo_ff);
    assign cur = {bridge_gnt_ff, ~gnt_n_ff};
    // bridge never times out; it has no flag
    assign expire = mask_ff.to_en && bus_idle && own_ff != BRIDGE_IDX
        && cnt_ff == CNT_LAST;

    // axi4-lite slave
    assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
    assign ar_take = i_arvalid && arready_ff;
    assign aridx = i_araddr[11:2];

    always_comb
    begin
        nxt_aw_held = (aw_held_ff || (i_awvalid && awready_ff)) && !do_wr;
        nxt_w_held = (w_held_ff || (i_wvalid && wready_ff)) && !do_wr;
        nxt_awidx = (i_awvalid && awready_ff) ? i_awaddr[11:2] : awidx_ff;
        nxt_wbyte = (i_wvalid && wready_ff) ? i_wdata[7:0] : wbyte_ff;
        nxt_wstrb0 = (i_wvalid && wready_ff) ? i_wstrb[0] : wstrb0_ff;
        nxt_awready = !nxt_aw_held;
        nxt_wready = !nxt_w_held;
        nxt_bvalid = (bvalid_ff && !i_bready) || do_wr;
        nxt_bresp = bresp_ff;
        if (do_wr)
            nxt_bresp = (awidx_ff == IDX_CTRL || awidx_ff == IDX_MASK
                || awidx_ff == IDX_STAT) ? RESP_OKAY : RESP_SLVERR;
        nxt_rvalid = (rvalid_ff && !i_rready) || ar_take;
        nxt_arready = !nxt_rvalid;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (ar_take)
        begin
            nxt_rresp = RESP_OKAY;
            case (aridx)
                IDX_CTRL: nxt_rdata = {24'h00_0000, ctrl_ff};
                IDX_MASK: nxt_rdata = {24'h00_0000, mask_ff};
                IDX_STAT: nxt_rdata = {26'h000_0000, to_flag_ff};
                default:
                begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (rst)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awidx_ff <= 10'h000;
            wbyte_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awidx_ff <= nxt_awidx;
            wbyte_ff <= nxt_wbyte;
            wstrb0_ff <= nxt_wstrb0;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // arbiter and register state
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        w1c = 6'h00;
        if (do_wr && wstrb0_ff)
        begin
            if (awidx_ff == IDX_CTRL)
                nxt_ctrl = arb_ctrl_s'(wbyte_ff);
            if (awidx_ff == IDX_MASK)
                nxt_mask = req_mask_s'(wbyte_ff);
            if (awidx_ff == IDX_STAT)
                w1c = wbyte_ff[5:0];
        end
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_own = own_ff;
        nxt_last_hi = last_hi_ff;
        nxt_last_lo = last_lo_ff;
        nxt_gnt_n = gnt_n_ff;
        nxt_bridge_gnt = bridge_gnt_ff;
        nxt_to_flag = to_flag_ff & ~w1c;
        // clearing a flag also lifts the automatic mask it caused
        nxt_automask = automask_ff & ~w1c;
        case (state_ff)
            ST_ARB:
            begin
                nxt_cnt = 8'h00;
                if (bus_idle)
                begin
                    if (pick_hi[3])
                    begin
                        nxt_own = pick_hi[2:0];
                        nxt_last_hi = pick_hi[2:0];
                        nxt_state = ST_WAIT;
                    end
                    else if (pick_lo[3])
                    begin
                        nxt_own = pick_lo[2:0];
                        nxt_last_lo = pick_lo[2:0];
                        nxt_state = ST_WAIT;
                    end
                    else if (ctrl_ff.park)
                        nxt_own = BRIDGE_IDX;
                    {nxt_bridge_gnt, nxt_gnt_n} = (pick_hi[3] || pick_lo[3]
                        || ctrl_ff.park) ? {1'b0, 6'h3f} ^ 7'(7'h01 << nxt_own)
                        : {bridge_gnt_ff, gnt_n_ff};
                end
            end
            ST_WAIT:
            begin
                if (!frame_s2_ff)
                begin
                    nxt_state = ST_BUSY;
                    nxt_cnt = 8'h00;
                end
                else if (!req_raw[own_ff])
                    nxt_state = ST_ARB;
                else if (expire)
                begin
                    nxt_to_flag[own_ff] = 1'b1;
                    if (mask_ff.auto_mask)
                        nxt_automask[own_ff] = 1'b1;
                    nxt_gnt_n = 6'h3f;
                    nxt_bridge_gnt = 1'b0;
                    nxt_state = ST_ARB;
                end
                else if (mask_ff.to_en && bus_idle)
                    nxt_cnt = 8'(cnt_ff + 8'h01);
            end
            ST_BUSY:
                if (frame_s2_ff)
                    nxt_state = ST_ARB;
            default: nxt_state = ST_ARB;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (rst)
        begin
            ctrl_ff <= arb_ctrl_s'(CTRL_RST);
            mask_ff <= req_mask_s'(MASK_RST);
            to_flag_ff <= STAT_RST;
            automask_ff <= 6'h00;
            state_ff <= ST_ARB;
            cnt_ff <= 8'h00;
            own_ff <= BRIDGE_IDX;
            last_hi_ff <= BRIDGE_IDX;
            last_lo_ff <= BRIDGE_IDX;
            gnt_n_ff <= 6'h3f;
            bridge_gnt_ff <= 1'b0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            mask_ff <= nxt_mask;
            to_flag_ff <= nxt_to_flag;
            automask_ff <= nxt_automask;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            own_ff <= nxt_own;
            last_hi_ff <= nxt_last_hi;
            last_lo_ff <= nxt_last_lo;
            gnt_n_ff <= nxt_gnt_n;
            bridge_gnt_ff <= nxt_bridge_gnt;
        end
    end

    assign o_awready = awready_ff;
    assign o_wready = wready_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;
    assign o_grant_out_n = gnt_n_ff;
    assign o_bridge_gnt = bridge_gnt_ff;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (rst);

    sequence s_arb_idle;
        state_ff == ST_ARB && bus_idle;
    endsequence
    sequence s_expire;
        state_ff == ST_WAIT && frame_s2_ff && req_raw[own_ff] && expire;
    endsequence

    property p_one_grant;
        $onehot0({bridge_gnt_ff, ~gnt_n_ff});
    endproperty
    a_one_grant: assert property (p_one_grant) else $error("two grants at once");
    property p_reset_vals;
        $past(rst) |-> ctrl_ff == CTRL_RST && mask_ff == MASK_RST && to_flag_ff == 6'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
    property p_park_bridge;
        s_arb_idle ##0 (req_raw == 7'h00 && ctrl_ff.park) |=> bridge_gnt_ff && gnt_n_ff == 6'h3f;
    endproperty
    a_park_bridge: assert property (p_park_bridge) else $error("not parked on bridge");
    property p_park_last;
        s_arb_idle ##0 (req_raw == 7'h00 && !ctrl_ff.park) |=> $stable(cur);
    endproperty
    a_park_last: assert property (p_park_last) else $error("parking moved");
    property p_tier_first;
        s_arb_idle ##0 (hi_req != 7'h00) |=> (cur & $past(tier7)) != 7'h00;
    endproperty
    a_tier_first: assert property (p_tier_first) else $error("low tier beat high");
    property p_flag_set;
        s_expire |=> to_flag_ff[own_ff] && gnt_n_ff == 6'h3f && state_ff == ST_ARB;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("time-out not flagged");
    property p_auto_mask;
        s_expire ##0 mask_ff.auto_mask |=> automask_ff[own_ff] && !req_raw[own_ff];
    endproperty
    a_auto_mask: assert property (p_auto_mask) else $error("no auto mask");
    property p_no_timeout;
        !mask_ff.to_en |=> (to_flag_ff & ~$past(to_flag_ff)) == 6'h00;
    endproperty
    a_no_timeout: assert property (p_no_timeout) else $error("flag while disabled");
    property p_ignored;
        s_arb_idle ##0 (pick_hi[3] || pick_lo[3]) |=> (~gnt_n_ff & $past(mask_ff.ignore)) == 6'h00;
    endproperty
    a_ignored: assert property (p_ignored) else $error("ignored request granted");
    property p_frame_start;
        state_ff == ST_WAIT && !frame_s2_ff |=> state_ff == ST_BUSY && cnt_ff == 8'h00;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame missed");
endmodule : sec_bus_arbiter

// ===== rtl/sec_arb_pkg.sv
// constants, types and register layout for the secondary bus arbiter
// assumes a single 10 MHz clock that is also the secondary bus clock
// Operation
// - grant through two priority tiers, rotating within each tier
// - after reset only the bridge sits in the high tier
// - idle with no requests parks on last master, or bridge if park set
// - control bit 6 puts the bridge low (0) or high (1); resets to 1
// - control bits 5..0 put each external requester low (0) or high (1)
// - time-out off when enable clear; 16 bus clocks when set
// - count starts on idle bus after grant; no frame at expiry means dead
// - auto-mask bit set masks a timed-out requester; clear means no masking
// - ignore bits 5..0 drop matching external requests when set
// - link, global or power-on reset restore control 40h and mask 00h
// - per-requester time-out flags set on expiry, cleared by software
package sec_arb_pkg;
    localparam int REQ_N = 6;
    localparam logic [2:0] BRIDGE_IDX = 3'h6;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL = 10'h0dc;
    localparam logic [9:0] IDX_MASK = 10'h0dd;
    localparam logic [9:0] IDX_STAT = 10'h0de;
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [5:0] STAT_RST = 6'h00;
    localparam int PARK_BIT = 7;
    localparam int BTIER_BIT = 6;
    localparam int TOEN_BIT = 7;
    localparam int AUTO_BIT = 6;
    localparam int TIMEOUT_BUS_CLKS = 16;
    localparam int MCLK_PER_BUS_CLK = 1;
    localparam int TIMEOUT_CYCLES = TIMEOUT_BUS_CLKS * MCLK_PER_BUS_CLK;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0]
    {
        ST_ARB = 2'b00,
        ST_WAIT = 2'b01,
        ST_BUSY = 2'b11
    } arb_state_e;
    typedef struct packed
    {
        logic park;
        logic bridge_tier;
        logic [5:0] tier;
    } arb_ctrl_s;
    typedef struct packed
    {
        logic to_en;
        logic auto_mask;
        logic [5:0] ignore;
    } req_mask_s;
endpackage : sec_arb_pkg

// ===== tb/ext_masters.sv
// behavioural model of the six external masters on the secondary bus
// assumes grants are sampled on i_mclk; frame and irdy have pull-ups
`timescale 1ns/1ps
module ext_masters (
    // clock
    input wire logic i_mclk,
    // bench control: who wants the bus, who never starts
    input wire logic [5:0] i_want,
    input wire logic [5:0] i_dead,
    // bus side
    input wire logic [5:0] i_grant_n,
    output logic [5:0] o_req_n,
    output logic o_frame_n,
    output logic o_irdy_n
);
    logic [5:0] served_ff = 6'h00;
    logic [2:0] phase_ff = 3'h0;
    logic [2:0] own_ff = 3'h0;
    // request held until granted and the transfer has begun
    assign o_req_n = ~(i_want & ~served_ff);
    // released lines return to the pull-up level, never a stale low
    assign o_frame_n = !(phase_ff inside {3'h1, 3'h2, 3'h3});
    assign o_irdy_n = !(phase_ff inside {3'h2, 3'h3, 3'h4});
    always @(posedge i_mclk)
    begin
        // drop request while frame is still low so no second grant follows
        served_ff <= (served_ff | ((phase_ff == 3'h2) ? 6'(6'h01 << own_ff) : 6'h00)) & i_want;
        if (phase_ff != 3'h0)
        begin
            phase_ff <= (phase_ff == 3'h5) ? 3'h0 : phase_ff + 3'h1;
        end
        else
        begin
            // start only on own grant with the bus idle (phase 0)
            for (int i = 0; i < 6; i++)
                if (!o_req_n[i] && !i_dead[i] && !i_grant_n[i])
                begin
                    phase_ff <= 3'h1;
                    own_ff <= 3'(i);
                end
        end
    end
endmodule : ext_masters

// ===== tb/testbench.sv
// self-checking bench for the secondary bus arbiter and its register bus
// assumes ext_masters on the bus side and a 10 MHz clock
`timescale 1ns/1ps
module testbench;
    import sec_arb_pkg::*;
    localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [11:0] A_MASK = {IDX_MASK, 2'b00};
    localparam logic [11:0] A_STAT = {IDX_STAT, 2'b00};
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_link_reset = 1'b0;
    logic i_global_reset_input_n = 1'b1;
    logic [11:0] i_awaddr = 12'h000;
    logic [11:0] i_araddr = 12'h000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0] i_wstrb = 4'h0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_bridge_req = 1'b0;
    logic [5:0] want = 6'h00, dead = 6'h00, req_n, o_grant_out_n;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_bridge_gnt;
    logic frame_n, irdy_n;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [33:0] rq[$];
    logic [6:0] gq[$];
    logic [6:0] gprev = 7'h00;
    logic [7:0] r;
    int k;
    int n_fail = 0;
    int tests_run = 0;
    wire logic [6:0] gv = {o_bridge_gnt, ~o_grant_out_n};

    sec_bus_arbiter #(.TO_CLKS(TIMEOUT_CYCLES)) sec_bus_arbiter_i (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_link_reset(i_link_reset),
        .i_global_reset_input_n(i_global_reset_input_n),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .i_request_in_n(req_n), .o_grant_out_n(o_grant_out_n), .i_frame_n(frame_n),
        .i_irdy_n(irdy_n), .i_bridge_req(i_bridge_req), .o_bridge_gnt(o_bridge_gnt));
    ext_masters ext_masters_i (.i_mclk(i_mclk), .i_want(want), .i_dead(dead),
        .i_grant_n(o_grant_out_n), .o_req_n(req_n), .o_frame_n(frame_n), .o_irdy_n(irdy_n));

    initial
    begin
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // every open-ended wait loop goes through here so a hang ends the run
    task automatic step();
        @(posedge i_mclk);
        k++;
        if (k > 400)
        begin
            n_fail++;
            complete_run();
        end
    endtask : step

    task automatic wait_g(input logic [6:0] v);
        k = 0;
        while (gv !== v)
            step();
    endtask : wait_g

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] e);
        @(posedge i_mclk);
        k = 0;
        rq.push_back({e, 32'h0000_0000});
        i_awaddr <= a;
        i_wdata <= {24'h00_0000, d};
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do
        begin
            step();
            if (i_awvalid && o_awready)
                i_awvalid <= 1'b0;
            if (i_wvalid && o_wready)
                i_wvalid <= 1'b0;
        end while (!o_bvalid);
        i_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        @(posedge i_mclk);
        k = 0;
        rq.push_back(e);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do
        begin
            step();
            if (i_arvalid && o_arready)
                i_arvalid <= 1'b0;
        end while (!o_rvalid);
        i_rready <= 1'b0;
    endtask : rd

    // let every noted grant appear, the last transfer finish, then withdraw
    task automatic drain();
        k = 0;
        while (gq.size() > 0)
            step();
        repeat (10) @(posedge i_mclk);
        want <= 6'h00;
        @(posedge i_mclk);
    endtask : drain

    always @(posedge i_mclk)
    begin
        if (o_bvalid && i_bready)
            check({o_bresp, 32'h0000_0000}, rq.size() > 0 ? rq.pop_front() : 'x);
        if (o_rvalid && i_rready)
            check({o_rresp, o_rdata}, rq.size() > 0 ? rq.pop_front() : 'x);
        if (i_rstn && gv !== gprev && gv !== 7'h00)
        begin
            check(34'(gv), gq.size() > 0 ? 34'(gq.pop_front()) : 'x);
            check(34'($onehot0(gv)), 34'h1);
        end
        gprev <= gv;
    end

    initial
    begin
        void'($urandom(19));
        repeat (16) @(posedge i_mclk);
        i_rstn <= 1'b1;
        rd(A_CTRL, {RESP_OKAY, 24'h00_0000, CTRL_RST});
        rd(A_MASK, {RESP_OKAY, 24'h00_0000, MASK_RST});
        rd(A_STAT, {RESP_OKAY, 26'h000_0000, STAT_RST});
        rd(12'h000, {RESP_SLVERR, 32'h0000_0000});
        wr(12'h004, 8'hff, 4'h1, RESP_SLVERR);
        r = 8'($urandom) & 8'h7f;
        wr(A_CTRL, r, 4'h1, RESP_OKAY);
        wr(A_CTRL, 8'hff, 4'h0, RESP_OKAY);
        rd(A_CTRL, {RESP_OKAY, 24'h00_0000, r});
        wr(A_CTRL, CTRL_RST, 4'h1, RESP_OKAY);
        r = 8'($urandom) & 8'h3f;
        wr(A_MASK, r, 4'h1, RESP_OKAY);
        rd(A_MASK, {RESP_OKAY, 24'h00_0000, r});
        wr(A_MASK, MASK_RST, 4'h1, RESP_OKAY);
        // bridge and master 1 contend while master 0 owns the bus
        gq = '{7'h01, 7'h40, 7'h02};
        want <= 6'h01;
        k = 0;
        while (frame_n !== 1'b0)
            step();
        want <= 6'h03;
        i_bridge_req <= 1'b1;
        wait_g(7'h40);
        i_bridge_req <= 1'b0;
        drain();
        // rotation continues after the last winner, master 1
        gq = '{7'h04, 7'h01};
        want <= 6'h05;
        drain();
        // master 3 in the high tier beats master 1 that is next in rotation
        wr(A_CTRL, 8'h08, 4'h1, RESP_OKAY);
        gq = '{7'h08, 7'h02};
        want <= 6'h0a;
        drain();
        // ignored request never wins, honoured once the bit clears
        wr(A_MASK, 8'h20, 4'h1, RESP_OKAY);
        want <= 6'h20;
        repeat (30) @(posedge i_mclk);
        check(34'(gv), 34'h02);
        gq = '{7'h20};
        wr(A_MASK, 8'h00, 4'h1, RESP_OKAY);
        drain();
        gq = '{7'h40};
        wr(A_CTRL, 8'h80, 4'h1, RESP_OKAY);
        drain();
        wr(A_CTRL, CTRL_RST, 4'h1, RESP_OKAY);
        // master 4 never starts: kept while the time-out is off, then withdrawn and masked
        gq = '{7'h10};
        want <= 6'h10;
        dead <= 6'h10;
        wait_g(7'h10);
        repeat (30) @(posedge i_mclk);
        check(34'(gv), 34'h10);
        wr(A_MASK, 8'hc0, 4'h1, RESP_OKAY);
        k = 0;
        while (gv === 7'h10)
            step();
        check(34'(k >= TIMEOUT_CYCLES && k <= TIMEOUT_CYCLES + 2), 34'h1);
        rd(A_STAT, {RESP_OKAY, 32'h0000_0010});
        repeat (30) @(posedge i_mclk);
        check(34'(gv), 34'h00);
        want <= 6'h00;
        dead <= 6'h00;
        wr(A_STAT, 8'h10, 4'h1, RESP_OKAY);
        rd(A_STAT, {RESP_OKAY, 32'h0000_0000});
        // link reset and the global pin both restore defaults
        wr(A_CTRL, 8'h3f, 4'h1, RESP_OKAY);
        i_link_reset <= 1'b1;
        @(posedge i_mclk);
        i_link_reset <= 1'b0;
        rd(A_CTRL, {RESP_OKAY, 24'h00_0000, CTRL_RST});
        wr(A_MASK, 8'h3f, 4'h1, RESP_OKAY);
        i_global_reset_input_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_global_reset_input_n <= 1'b1;
        repeat (5) @(posedge i_mclk);
        rd(A_MASK, {RESP_OKAY, 24'h00_0000, MASK_RST});
        repeat (4) @(posedge i_mclk);
        complete_run();
    end

    initial
    begin
        repeat (100000) @(posedge i_mclk);
        n_fail++;
        complete_run();
    end
endmodule : testbench
